// ### src/usart_req_pkg.sv
// constants shared by the serial request block and its transmit shifter
package usart_req_pkg;
    localparam int unsigned CLK_HZ   = 100_000_000;
    localparam int unsigned BAUD_HZ  = 115_200;
    // bit time in cycles, rounded down
    localparam int unsigned BAUD_CYC = CLK_HZ / BAUD_HZ;
    localparam int unsigned BAUD_W   = 10;
    localparam logic [BAUD_W-1:0] BAUD_LAST = BAUD_W'(BAUD_CYC - 1);
    localparam logic [3:0] FRAME_BITS = 4'hA;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned RX_DEPTH = 2;

    localparam logic [ADDR_W-1:0] OFS_DATA   = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_FLAGS  = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_EN_SET = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_EN_CLR = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;

    localparam int unsigned FLG_DRE   = 0;
    localparam int unsigned FLG_TXC   = 1;
    localparam int unsigned FLG_RXC   = 2;
    localparam int unsigned FLG_RXS   = 3;
    localparam int unsigned FLG_CTS_INPUT_CHANGE = 4;
    localparam int unsigned FLG_RX_BREAK = 5;
    localparam int unsigned FLG_ERR   = 7;

    localparam logic [7:0] FLAGS_RST = 8'h01;
    localparam logic [7:0] EN_RST    = 8'h00;
    localparam logic [7:0] FLAGS_IMPL = 8'hBF;
    localparam logic [7:0] W1C_MASK  = 8'hBE;

    localparam int unsigned ST_TX_BUSY = 0;
    localparam int unsigned ST_RX_CNT  = 1;

    typedef enum logic [0:0] {
        TX_IDLE  = 1'b0,
        TX_SHIFT = 1'b1
    } tx_state_t;
endpackage

// ### src/tx_shift_if.sv
// link between the data register logic and the transmit shift register
`timescale 1ns/1ps
`default_nettype none
interface tx_shift_if;
    logic       load;
    logic [7:0] data;
    logic       busy;
    logic       done;
    logic       txd;
    modport owner (output load, output data,
                   input busy, input done, input txd);
    modport shifter (input load, input data,
                     output busy, output done, output txd);
endinterface
`default_nettype wire

// ### src/tx_shifter.sv
// transmit shift register: start bit, eight data bits, stop bit
`timescale 1ns/1ps
`default_nettype none
module tx_shifter
    import usart_req_pkg::*;
(
    input  wire logic    i_clk,
    input  wire logic    i_rst_n,
    tx_shift_if.shifter  txs
);
    typedef struct packed {
        tx_state_t         st;
        logic [9:0]        sh;
        logic [3:0]        bits;
        logic [BAUD_W-1:0] div;
        logic              txd;
        logic              done;
    } shift_state_t;

    shift_state_t q;
    shift_state_t d;

    always_comb begin
        d = q;
        d.done = 1'b0;
        unique case (q.st)
            TX_IDLE: begin
                d.txd = 1'b1;
                if (txs.load) begin
                    d.st   = TX_SHIFT;
                    d.sh   = {1'b1, txs.data, 1'b0};
                    d.bits = 4'h0;
                    d.div  = '0;
                    d.txd  = 1'b0;
                end
            end
            TX_SHIFT: begin
                // one bit per enable from the baud divider
                if (q.div == BAUD_LAST) begin
                    d.div  = '0;
                    d.bits = q.bits + 4'h1;
                    d.sh   = {1'b1, q.sh[9:1]};
                    if (q.bits == FRAME_BITS - 4'h1) begin
                        d.st   = TX_IDLE;
                        d.txd  = 1'b1;
                        d.done = 1'b1;
                    end else begin
                        d.txd = q.sh[1];
                    end
                end else begin
                    d.div = q.div + BAUD_W'(1);
                end
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '{st: TX_IDLE, sh: 10'h3FF, bits: 4'h0, div: '0,
                   txd: 1'b1, done: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign txs.busy = (q.st == TX_SHIFT);
    assign txs.done = q.done;
    assign txs.txd  = q.txd;
endmodule
`default_nettype wire

// ### src/usart_req_top.sv
// serial unit request logic: flags, enables, interrupt and dma requests
// Notes on behaviour
// - transmit dma request stands while the data buffer is empty
// - receive dma request stands while the receive fifo holds data
// - only buffer empty and receive complete make dma requests
// - seven interrupt sources: empty, rx done, tx done, start, cts, brk, err
// - interrupt requests are meant to wake the device from sleep; O_IRQ is registered, so it cannot wake without a clock
// - each source has its own flag, set when its condition occurs
// - one to enable-set sets an enable, one to enable-clear clears it
// - interrupt raised exactly when a flag and its enable are both set
// - request persists until flag cleared, enable cleared or reset
// - all sources share one request line; flags tell the cause
// - tx complete, bit 1, set when frame sent and buffer empty
// - tx complete cleared by writing one or by writing data
// - buffer empty flag, bit 0, set while the buffer is empty
// - buffer empty flag cleared only by writing data
// - writing one to bit 0, or zero to bits 0 and 1, is ignored
`timescale 1ns/1ps
`default_nettype none
module usart_req_top
    import usart_req_pkg::*;
(
    input  wire logic                        I_CLK_SYS,
    input  wire logic                        I_RST_N,
    input  wire logic                        I_PSEL,
    input  wire logic                        I_PENABLE,
    input  wire logic                        I_PWRITE,
    input  wire logic [usart_req_pkg::ADDR_W-1:0] I_PADDR,
    input  wire logic [usart_req_pkg::DATA_W-1:0] I_PWDATA,
    input  wire logic [3:0]                  I_PSTRB,
    output var  logic [usart_req_pkg::DATA_W-1:0] O_PRDATA,
    output var  logic                        O_PREADY,
    output var  logic                        O_PSLVERR,
    input  wire logic                        I_RX_VALID,
    input  wire logic [7:0]                  I_RX_DATA,
    input  wire logic                        I_RX_START,
    input  wire logic                        I_RX_BREAK,
    input  wire logic                        I_RX_ERROR,
    input  wire logic                        I_CTS_N,
    output var  logic                        O_TXD,
    output var  logic                        O_IRQ,
    output var  logic                        O_DMA_TX_REQ,
    output var  logic                        O_DMA_RX_REQ
);
    import usart_req_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0]        prdata;
        logic                     pready;
        logic                     pslverr;
        logic [7:0]               flags;
        logic [7:0]               en;
        logic                     tx_full;
        logic [7:0]               tx_buf;
        logic                     load;
        logic [7:0]               load_data;
        logic [RX_DEPTH-1:0][7:0] rx_mem;
        logic [1:0]               rx_cnt;
        logic                     rx_rd;
        logic [2:0]               cts_s;
        logic                     irq;
        logic                     dma_tx;
        logic                     dma_rx;
        logic                     txd;
    } top_state_t;

    top_state_t q;
    top_state_t d;

    logic [1:0] rst_sync_q;
    logic       rst_n;

    tx_shift_if txs ();

    // reset enters asynchronously but is released through two flops
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    tx_shifter u_shift (
        .i_clk   (I_CLK_SYS),
        .i_rst_n (rst_n),
        .txs     (txs.shifter)
    );

    assign txs.load = q.load;
    assign txs.data = q.load_data;

    logic       setup;
    logic       wr_done;
    logic       rd_done;
    logic       mapped;
    logic       wr_b0;
    logic [7:0] wbyte;
    logic [7:0] fset;
    logic [7:0] fclr;
    logic       data_wr;
    logic       data_rd;
    logic       rx_push;
    logic       rx_pop;
    logic       rx_ovf;
    logic [DATA_W-1:0] rdata;

    always_comb begin
        d = q;
        setup   = I_PSEL && !I_PENABLE;
        wr_done = I_PSEL && I_PENABLE && q.pready && I_PWRITE;
        rd_done = I_PSEL && I_PENABLE && q.pready && !I_PWRITE;
        wbyte   = I_PWDATA[7:0];
        wr_b0   = wr_done && I_PSTRB[0] && !q.pslverr;
        mapped  = (I_PADDR == OFS_DATA) || (I_PADDR == OFS_FLAGS) ||
                  (I_PADDR == OFS_EN_SET) || (I_PADDR == OFS_EN_CLR) ||
                  (I_PADDR == OFS_STATUS);

        // read data is captured in the setup cycle; one wait-free access
        rdata = '0;
        if (I_PADDR == OFS_DATA) begin
            rdata[7:0] = q.rx_mem[q.rx_rd];
        end else if (I_PADDR == OFS_FLAGS) begin
            rdata[7:0] = q.flags;
        end else if (I_PADDR == OFS_EN_SET || I_PADDR == OFS_EN_CLR) begin
            rdata[7:0] = q.en;
        end else if (I_PADDR == OFS_STATUS) begin
            rdata[ST_TX_BUSY]             = txs.busy;
            rdata[ST_RX_CNT +: 2]         = q.rx_cnt;
        end
        d.pready  = setup;
        d.pslverr = setup && !mapped;
        d.prdata  = setup ? rdata : q.prdata;

        // three-stage sampler on the cts pin; first stage feeds only stage two
        d.cts_s = {q.cts_s[1:0], I_CTS_N};

        // transmit side: one-word data buffer ahead of the shift register
        data_wr = wr_b0 && (I_PADDR == OFS_DATA) && !q.tx_full;
        d.load  = 1'b0;
        if (q.tx_full && !txs.busy && !q.load) begin
            d.load      = 1'b1;
            d.load_data = q.tx_buf;
            d.tx_full   = 1'b0;
        end
        if (data_wr) begin
            d.tx_full = 1'b1;
            d.tx_buf  = wbyte;
        end

        // receive fifo; a word arriving while full and not read that cycle is lost and flags error
        data_rd = rd_done && (I_PADDR == OFS_DATA) && !q.pslverr;
        rx_pop  = data_rd && (q.rx_cnt != 2'h0);
        rx_ovf  = I_RX_VALID && (q.rx_cnt == 2'(RX_DEPTH)) && !rx_pop;
        rx_push = I_RX_VALID && !rx_ovf;
        if (rx_push) begin
            d.rx_mem[1'(q.rx_rd + 1'(q.rx_cnt))] = I_RX_DATA;
        end
        if (rx_pop) begin
            d.rx_rd = ~q.rx_rd;
        end
        d.rx_cnt = q.rx_cnt + 2'(rx_push) - 2'(rx_pop);

        // sources that set their flag this cycle
        fset = 8'h00;
        fset[FLG_TXC]   = txs.done && !d.tx_full && !d.load;
        fset[FLG_RXC]   = rx_push;
        fset[FLG_RXS]   = I_RX_START;
        fset[FLG_CTS_INPUT_CHANGE] = q.cts_s[2] != q.cts_s[1];
        fset[FLG_RX_BREAK] = I_RX_BREAK;
        fset[FLG_ERR]   = I_RX_ERROR || rx_ovf;

        // write-one-to-clear; zeros and bit 0 ignored
        fclr = 8'h00;
        if (wr_b0 && (I_PADDR == OFS_FLAGS)) begin
            fclr = wbyte & W1C_MASK;
        end
        if (data_wr) begin
            fclr[FLG_TXC] = 1'b1;
        end
        if (data_rd && (d.rx_cnt == 2'h0)) begin
            fclr[FLG_RXC] = 1'b1;
        end
        // a flag that sets in the clearing cycle stays set
        d.flags = ((q.flags & ~fclr) | fset) & FLAGS_IMPL;
        d.flags[FLG_DRE] = !d.tx_full;

        if (wr_b0 && (I_PADDR == OFS_EN_SET)) begin
            d.en = (q.en | wbyte) & FLAGS_IMPL;
        end
        if (wr_b0 && (I_PADDR == OFS_EN_CLR)) begin
            d.en = q.en & ~wbyte;
        end

        // single level line from flags and enables; registered from the next flag values, so it
        // changes on the same edge as a flag and cannot wake without a clock
        d.irq    = |(d.flags & d.en);
        // only the empty buffer and received data ask the dma
        d.dma_tx = !d.tx_full;
        d.dma_rx = d.rx_cnt != 2'h0;
        d.txd    = txs.txd;
    end

    always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{prdata: '0, pready: 1'b0, pslverr: 1'b0,
                   flags: FLAGS_RST, en: EN_RST, tx_full: 1'b0,
                   tx_buf: 8'h00, load: 1'b0, load_data: 8'h00,
                   rx_mem: '0, rx_cnt: 2'h0, rx_rd: 1'b0,
                   cts_s: 3'h7, irq: 1'b0, dma_tx: 1'b1,
                   dma_rx: 1'b0, txd: 1'b1};
        end else begin
            q <= d;
        end
    end

    assign O_PRDATA     = q.prdata;
    assign O_PREADY     = q.pready;
    assign O_PSLVERR    = q.pslverr;
    assign O_IRQ        = q.irq;
    assign O_DMA_TX_REQ = q.dma_tx;
    assign O_DMA_RX_REQ = q.dma_rx;
    assign O_TXD        = q.txd;
endmodule
`default_nettype wire

// ### tb/usart_req_props.sv
// assertions on the request block's ports
`timescale 1ns/1ps
`default_nettype none
module usart_req_props
    import usart_req_pkg::*;
(
    input wire logic                              I_CLK_SYS,
    input wire logic                              I_RST_N,
    input wire logic                              I_PSEL,
    input wire logic                              I_PENABLE,
    input wire logic                              I_PWRITE,
    input wire logic [usart_req_pkg::ADDR_W-1:0] I_PADDR,
    input wire logic [3:0]                        I_PSTRB,
    input wire logic                              I_RX_VALID,
    input wire logic                              O_PREADY,
    input wire logic                              O_PSLVERR,
    input wire logic                              O_IRQ,
    input wire logic                              O_DMA_TX_REQ,
    input wire logic                              O_DMA_RX_REQ
);
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RST_N);
    logic acc;
    logic dwr;
    logic drd;
    assign acc = I_PSEL && I_PENABLE && O_PREADY;
    assign dwr = acc && I_PWRITE && I_PSTRB[0] && I_PADDR == OFS_DATA;
    assign drd = acc && !I_PWRITE && I_PADDR == OFS_DATA;
    a_tx_req_drop: assert property (dwr && O_DMA_TX_REQ |=> !O_DMA_TX_REQ)
        else $error("tx request kept after data write");
    a_tx_req_cause: assert property ($fell(O_DMA_TX_REQ) |-> $past(dwr))
        else $error("tx request fell without data write");
    a_rx_req_set: assert property (I_RX_VALID |=> O_DMA_RX_REQ)
        else $error("rx request missing after byte");
    a_rx_req_drop: assert property ($fell(O_DMA_RX_REQ) |-> $past(drd))
        else $error("rx request fell without data read");
    a_no_other_dma: assert property
        (!I_RX_VALID && !O_DMA_RX_REQ |=> !O_DMA_RX_REQ)
        else $error("rx request from another source");
    a_irq_persist: assert property ($fell(O_IRQ) |-> $past(acc))
        else $error("interrupt dropped without access");
    a_slverr_ready: assert property (O_PSLVERR |-> O_PREADY && I_PENABLE)
        else $error("error response outside access");
    a_ready_access: assert property
        (I_PSEL && !I_PENABLE |=> O_PREADY ##1 !O_PREADY)
        else $error("ready not one cycle after setup");
endmodule
bind usart_req_top usart_req_props u_props (.I_CLK_SYS, .I_RST_N, .I_PSEL,
    .I_PENABLE, .I_PWRITE, .I_PADDR, .I_PSTRB, .I_RX_VALID, .O_PREADY,
    .O_PSLVERR, .O_IRQ, .O_DMA_TX_REQ, .O_DMA_RX_REQ);
`default_nettype wire

// ### tb/irq_host_model.sv
// stand-in for the interrupt and dma controllers: counts raised interrupt and rx dma requests
`timescale 1ns/1ps
`default_nettype none
module irq_host_model (
    input  wire logic       i_clk,
    input  wire logic       i_irq,
    input  wire logic       i_dma_rx,
    output var  logic [7:0] o_irq_cnt,
    output var  logic [7:0] o_rx_cnt
);
    logic irq_q = 1'b0;
    logic rx_q  = 1'b0;
    initial o_irq_cnt = 8'h00;
    initial o_rx_cnt  = 8'h00;
    // a level line is only seen as a new request on its rising edge
    always @(posedge i_clk) begin
        irq_q <= i_irq;
        rx_q  <= i_dma_rx;
        if (i_irq && !irq_q) o_irq_cnt <= o_irq_cnt + 8'h01;
        if (i_dma_rx && !rx_q) o_rx_cnt <= o_rx_cnt + 8'h01;
    end
endmodule
`default_nettype wire

// ### tb/tb.sv
// self-checking bench for the serial request block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import usart_req_pkg::*;
    localparam int FRAME = 10 * BAUD_CYC + 60;
    logic        clk, rst_n, psel, pen, pwr, rxv, rx_start, rxb, rxe, cts_n;
    logic [3:0]  pstrb;
    logic        pready, pslverr, txd, irq, dtx, drx, err;
    logic [7:0]  paddr, rxd, icnt, rcnt;
    logic [31:0] pwdata, prdata, q;
    int          n_fail = 0;
    int          total_checks = 0;

    usart_req_top DUT (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_PSEL(psel),
        .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
        .I_PWDATA(pwdata), .I_PSTRB(pstrb), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .I_RX_VALID(rxv),
        .I_RX_DATA(rxd), .I_RX_START(rx_start), .I_RX_BREAK(rxb),
        .I_RX_ERROR(rxe), .I_CTS_N(cts_n), .O_TXD(txd), .O_IRQ(irq),
        .O_DMA_TX_REQ(dtx), .O_DMA_RX_REQ(drx));
    irq_host_model host (.i_clk(clk), .i_irq(irq), .i_dma_rx(drx),
        .o_irq_cnt(icnt), .o_rx_cnt(rcnt));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    // request held from setup until pready is seen high at a rising edge;
    // data and error are taken at that edge, then the request is released
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        psel   <= 1'b1;
        pen    <= 1'b0;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk(pready, 1'b1);
        q   = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(q, e);
    endtask

    task automatic rx_byte(input logic [7:0] d);
        @(posedge clk);
        rxv <= 1'b1;
        rxd <= d;
        @(posedge clk);
        rxv <= 1'b0;
        @(negedge clk);
    endtask

    // follow one frame on the line: start, eight bits lsb first, stop,
    // each sampled near the middle of its bit time
    task automatic chk_frame(input logic [7:0] b);
        int n;
        n = 0;
        while (txd !== 1'b0 && n < 100) begin
            @(negedge clk);
            n++;
        end
        repeat (BAUD_CYC / 2) @(negedge clk);
        chk(txd, 1'b0);
        for (int i = 0; i < 8; i++) begin
            repeat (BAUD_CYC) @(negedge clk);
            chk(txd, b[i]);
        end
        repeat (BAUD_CYC) @(negedge clk);
        chk(txd, 1'b1);
    endtask

    task automatic t_reset;
        rd(OFS_FLAGS, 32'h1);
        rd(OFS_EN_SET, 32'h0);
        chk(dtx, 1'b1);
        chk(drx, 1'b0);
        chk(txd, 1'b1);
        apb(1'b0, 8'hFC, 32'h0);
        chk(err, 1'b1);
        @(posedge clk);
        pstrb <= 4'hE;
        apb(1'b1, OFS_EN_SET, 32'h1);
        pstrb <= 4'hF;
        rd(OFS_EN_SET, 32'h0);
    endtask

    task automatic t_enable;
        apb(1'b1, OFS_EN_SET, 32'h1);
        @(negedge clk);
        chk(irq, 1'b1);
        apb(1'b1, OFS_FLAGS, 32'h1);
        rd(OFS_FLAGS, 32'h1);
        chk(irq, 1'b1);
        apb(1'b1, OFS_EN_CLR, 32'h1);
        @(negedge clk);
        chk(irq, 1'b0);
        rd(OFS_EN_SET, 32'h0);
        chk(icnt, 8'h01);
    endtask

    task automatic t_tx;
        apb(1'b1, OFS_DATA, 32'h55);
        @(negedge clk);
        chk(dtx, 1'b0);
        rd(OFS_FLAGS, 32'h1);
        chk(dtx, 1'b1);
        chk_frame(8'h55);
        repeat (500) @(posedge clk);
        rd(OFS_FLAGS, 32'h3);
        apb(1'b1, OFS_FLAGS, 32'h0);
        rd(OFS_FLAGS, 32'h3);
        apb(1'b1, OFS_FLAGS, 32'h2);
        rd(OFS_FLAGS, 32'h1);
        apb(1'b1, OFS_DATA, 32'hAA);
        repeat (FRAME) @(posedge clk);
        rd(OFS_FLAGS, 32'h3);
        apb(1'b1, OFS_DATA, 32'h0F);
        rd(OFS_FLAGS, 32'h1);
        repeat (FRAME) @(posedge clk);
        apb(1'b1, OFS_FLAGS, 32'h2);
        rd(OFS_FLAGS, 32'h1);
    endtask

    task automatic t_rx;
        rx_byte(8'hA5);
        chk(drx, 1'b1);
        rd(OFS_FLAGS, 32'h5);
        rd(OFS_DATA, 32'hA5);
        @(negedge clk);
        chk(drx, 1'b0);
        rx_byte(8'h01);
        rx_byte(8'h02);
        rx_byte(8'h03);
        rd(OFS_FLAGS, 32'h85);
        apb(1'b1, OFS_FLAGS, 32'h84);
        rd(OFS_FLAGS, 32'h1);
        rd(OFS_DATA, 32'h1);
        rd(OFS_DATA, 32'h2);
        chk(rcnt, 8'h02);
    endtask

    task automatic t_misc;
        @(posedge clk);
        rx_start   <= 1'b1;
        rxb   <= 1'b1;
        rxe   <= 1'b1;
        cts_n <= 1'b0;
        @(posedge clk);
        rx_start <= 1'b0;
        rxb <= 1'b0;
        rxe <= 1'b0;
        repeat (6) @(posedge clk);
        rd(OFS_FLAGS, 32'hB9);
        chk(drx, 1'b0);
        apb(1'b1, OFS_EN_SET, 32'h8);
        @(negedge clk);
        chk(irq, 1'b1);
        apb(1'b1, OFS_FLAGS, 32'h8);
        @(negedge clk);
        chk(irq, 1'b0);
        apb(1'b1, OFS_FLAGS, 32'hB0);
        rd(OFS_FLAGS, 32'h1);
    endtask

    task automatic summarize;
        if (n_fail == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        {psel, pen, pwr, rxv, rx_start, rxb, rxe} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        rxd = 8'h00;
        pstrb = 4'hF;
        cts_n = 1'b1;
        rst_n = 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_reset;
        t_enable;
        t_tx;
        t_rx;
        t_misc;
        summarize;
    end

    // the run needs about three frames; eight frames means a hang
    initial begin
        #(80 * FRAME);
        n_fail++;
        summarize;
    end
endmodule
`default_nettype wire
